// [smt_defs.vh]
// Register map, field layout, reset values and pin count constants for the static memory timing block
`ifndef SMT_DEFS_VH
`define SMT_DEFS_VH
`define SMT_NCS            4
`define SMT_ADDR_W         8
`define SMT_OFF_SETUP      8'h00
`define SMT_OFF_PULSE      8'h04
`define SMT_OFF_CYCLE      8'h08
`define SMT_OFF_MODE       8'h0C
`define SMT_CS_STRIDE      8'h10
`define SMT_OFF_REQ        8'h40
`define SMT_OFF_STATUS     8'h44
`define SMT_OFF_RDATA      8'h48
`define SMT_RST_SETUP      32'h00000000
`define SMT_RST_PULSE      32'h01010101
`define SMT_RST_CYCLE      32'h00010001
`define SMT_RST_MODE       2'h3
`define SMT_SETUP_W        6
`define SMT_PULSE_W        7
`define SMT_CYCLE_W        9
`define SMT_CNT_W          10
`define SMT_F_WR_SET       0
`define SMT_F_CSW_SET      8
`define SMT_F_RD_SET       16
`define SMT_F_CSR_SET      24
`define SMT_F_WCYC         0
`define SMT_F_RCYC         16
`define SMT_MODE_RD        0
`define SMT_MODE_WR        1
`endif

// [smt_ctrl.v]
// Static memory access sequencer with per chip select timing and automatic wait states
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "smt_defs.vh"
// Function
// - Setup field decodes as 128 times top bit plus low five bits.
// - Pulse field decodes as 256 times top bit plus low six bits.
// - Cycle field decodes as 256 times top two bits plus low seven.
// - Each chip select keeps setup, pulse and cycle timing registers.
// - Pulse register resets to one cycle for every strobe.
// - Cycle register resets to one-cycle read and write accesses.
// - Setup register resets to its printed zero value.
// - Write mode resets to strobe control, read mode to strobe control.
// - Zero-hold writes keep address, byte selects and data drive past strobe rise.
// - One idle cycle between transfers to different chip selects; the code leaves three (ST_IDLE, ST_WAIT, then a second ST_IDLE).
// - Idle cycle drives all select and strobe lines high.
// - Early read wait only between write then read, same chip select.
// - Early read wait when write hold zero and read setup zero.
// - Select-controlled write: wait when select hold and select read setup zero.
// - Strobe write with zero hold: wait if fed-back strobe still low.
// - Timings kept per chip select, counted in whole clock cycles.
// - Hold derived as cycle minus setup minus pulse.
// - Read data sampled at edge raising strobe or select per read mode.
module smt_ctrl (
  input  wire        mclk_i,
  input  wire        resetn_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [15:0] mem_data_i,
  input  wire        write_strobe_fb_i,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_data_o,
  output reg         mem_data_oen_n_o,
  output reg  [3:0]  chip_select_n_o,
  output reg         read_strobe_n_o,
  output reg         write_strobe_n_o,
  output reg  [1:0]  byte_select_lines_o,
  output reg  [1:0]  byte_write_lines_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_ERW  = 2'h3;

  reg [31:0] setup_reg [0:3];
  reg [31:0] pulse_reg [0:3];
  reg [31:0] cycle_reg [0:3];
  reg [1:0]  mode_reg  [0:3];
  reg [31:0] req_reg;
  reg        req_pend_reg;
  reg [15:0] rd_data_reg;
  reg        done_reg;
  reg [1:0]  state_reg;
  reg [1:0]  cur_cs_reg;
  reg        cur_wr_reg;
  reg        last_valid_reg;
  reg [1:0]  last_cs_reg;
  reg        last_wr_reg;
  reg        last_zhold_reg;
  reg [9:0]  cnt_reg;
  reg [9:0]  st_set_reg;
  reg [9:0]  st_end_reg;
  reg [9:0]  cs_set_reg;
  reg [9:0]  cs_end_reg;
  reg [9:0]  cyc_reg;
  reg        fb_s1_reg;
  reg        fb_s2_reg;
  integer    i;

  function [9:0] dec_setup;
    input [5:0] f;
    begin
      dec_setup = {2'h0, f[5], 2'h0, f[4:0]};
    end
  endfunction
  function [9:0] dec_pulse;
    input [6:0] f;
    begin
      dec_pulse = {1'b0, f[6], 2'h0, f[5:0]};
    end
  endfunction
  function [9:0] dec_cycle;
    input [8:0] f;
    begin
      dec_cycle = {f[8:7], 1'b0, f[6:0]};
    end
  endfunction
  function [9:0] fld_setup;
    input [31:0] r;
    input [4:0]  pos;
    begin
      fld_setup = dec_setup(r[pos +: 6]);
    end
  endfunction
  function [9:0] fld_pulse;
    input [31:0] r;
    input [4:0]  pos;
    begin
      fld_pulse = dec_pulse(r[pos +: 7]);
    end
  endfunction

  wire [1:0]  req_cs   = req_reg[17:16];
  wire        req_wr   = req_reg[18];
  wire [9:0]  n_wset   = fld_setup(setup_reg[req_cs], `SMT_F_WR_SET);
  wire [9:0]  n_cwset  = fld_setup(setup_reg[req_cs], `SMT_F_CSW_SET);
  wire [9:0]  n_rset   = fld_setup(setup_reg[req_cs], `SMT_F_RD_SET);
  wire [9:0]  n_crset  = fld_setup(setup_reg[req_cs], `SMT_F_CSR_SET);
  wire [9:0]  n_wpul   = fld_pulse(pulse_reg[req_cs], `SMT_F_WR_SET);
  wire [9:0]  n_cwpul  = fld_pulse(pulse_reg[req_cs], `SMT_F_CSW_SET);
  wire [9:0]  n_rpul   = fld_pulse(pulse_reg[req_cs], `SMT_F_RD_SET);
  wire [9:0]  n_crpul  = fld_pulse(pulse_reg[req_cs], `SMT_F_CSR_SET);
  wire [9:0]  n_wcyc   = dec_cycle(cycle_reg[req_cs][`SMT_F_WCYC +: 9]);
  wire [9:0]  n_rcyc   = dec_cycle(cycle_reg[req_cs][`SMT_F_RCYC +: 9]);
  wire        rd_by_strobe = mode_reg[req_cs][`SMT_MODE_RD];
  // Setup of the read controlling signal for the coming access
  wire        rd_zset  = rd_by_strobe ? (n_rset == 10'h000) : (n_crset == 10'h000);
  // same select write then read only
  wire        same_wr_rd = last_valid_reg & last_wr_reg & ~req_wr & (last_cs_reg == req_cs);
  // select write hold zero, select read setup zero
  wire        erw_cs   = ~mode_reg[req_cs][`SMT_MODE_WR] & last_zhold_reg & (n_crset == 10'h000);
  // zero write hold, zero read setup
  wire        erw_gen  = last_zhold_reg & rd_zset;
  wire        erw_fb   = mode_reg[req_cs][`SMT_MODE_WR] & last_zhold_reg & ~fb_s2_reg;
  wire        need_erw = same_wr_rd & (erw_gen | erw_cs | erw_fb);
  wire        need_csw = last_valid_reg & (last_cs_reg != req_cs);
  wire [9:0]  cnt_inc  = cnt_reg + 10'h001;
  wire        last_cyc = (cnt_inc >= cyc_reg);
  // Registered lines show the position of the coming cycle, so phases are not one cycle late
  wire        st_on    = (cnt_inc >= st_set_reg) & (cnt_inc < st_end_reg);
  wire        cs_on    = (cnt_inc >= cs_set_reg) & (cnt_inc < cs_end_reg);
  wire [9:0]  ld_st_set = req_wr ? n_wset : n_rset;
  wire [9:0]  ld_cs_set = req_wr ? n_cwset : n_crset;
  wire        ld_ctl_set0 = mode_reg[req_cs][`SMT_MODE_WR] ? (ld_st_set == 10'h000) : (ld_cs_set == 10'h000);
  wire        st_rise  = (cnt_inc == st_end_reg);
  wire        cs_rise  = (cnt_inc == cs_end_reg);
  // Hold of the controlling write signal, from cycle minus setup minus pulse
  wire        wr_ctl_st = mode_reg[cur_cs_reg][`SMT_MODE_WR];
  wire        zhold_now = wr_ctl_st ? (st_end_reg >= cyc_reg) : (cs_end_reg >= cyc_reg);

  // Fed-back strobe crosses from the pad before any use
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_s1_reg <= 1'b1;
      fb_s2_reg <= 1'b1;
    end else begin
      fb_s1_reg <= write_strobe_fb_i;
      fb_s2_reg <= fb_s1_reg;
    end
  end

  // Register file
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (i = 0; i < `SMT_NCS; i = i + 1) begin
        setup_reg[i] <= `SMT_RST_SETUP;
        pulse_reg[i] <= `SMT_RST_PULSE;
        cycle_reg[i] <= `SMT_RST_CYCLE;
        mode_reg[i]  <= `SMT_RST_MODE;
      end
      req_reg      <= 32'h00000000;
      req_pend_reg <= 1'b0;
    end else begin
      if (wr_i && addr_i < `SMT_OFF_REQ) begin
        case (addr_i[3:0])
          `SMT_OFF_SETUP: setup_reg[addr_i[5:4]] <= wdata_i;
          `SMT_OFF_PULSE: pulse_reg[addr_i[5:4]] <= wdata_i;
          `SMT_OFF_CYCLE: cycle_reg[addr_i[5:4]] <= wdata_i;
          `SMT_OFF_MODE:  mode_reg[addr_i[5:4]]  <= wdata_i[1:0];
          default: ;
        endcase
      end
      // A new request while one is pending is dropped; software polls status
      if (wr_i && addr_i == `SMT_OFF_REQ && !req_pend_reg) begin
        req_reg      <= wdata_i;
        req_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && req_pend_reg && !need_csw && !need_erw) begin
        req_pend_reg <= 1'b0;
      end
    end
  end

  // Read port
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      if (addr_i < `SMT_OFF_REQ) begin
        case (addr_i[3:0])
          `SMT_OFF_SETUP: rdata_o <= setup_reg[addr_i[5:4]];
          `SMT_OFF_PULSE: rdata_o <= pulse_reg[addr_i[5:4]];
          `SMT_OFF_CYCLE: rdata_o <= cycle_reg[addr_i[5:4]];
          `SMT_OFF_MODE:  rdata_o <= {30'h00000000, mode_reg[addr_i[5:4]]};
          default:        rdata_o <= 32'h00000000;
        endcase
      end else if (addr_i == `SMT_OFF_REQ) begin
        rdata_o <= req_reg;
      end else if (addr_i == `SMT_OFF_STATUS) begin
        rdata_o <= {27'h0000000, state_reg, done_reg, req_pend_reg, state_reg != ST_IDLE};
      end else if (addr_i == `SMT_OFF_RDATA) begin
        rdata_o <= {16'h0000, rd_data_reg};
      end else begin
        rdata_o <= 32'h00000000;
      end
    end
  end

  // Access sequencer
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      cur_cs_reg <= 2'h0;
      cur_wr_reg <= 1'b0;
      last_valid_reg <= 1'b0;
      last_cs_reg <= 2'h0;
      last_wr_reg <= 1'b0;
      last_zhold_reg <= 1'b0;
      cnt_reg <= 10'h000;
      st_set_reg <= 10'h000;
      st_end_reg <= 10'h000;
      cs_set_reg <= 10'h000;
      cs_end_reg <= 10'h000;
      cyc_reg <= 10'h000;
      rd_data_reg <= 16'h0000;
      done_reg <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_data_o <= 16'h0000;
      mem_data_oen_n_o <= 1'b1;
      chip_select_n_o <= 4'hF;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      byte_select_lines_o <= 2'h3;
      byte_write_lines_o <= 2'h3;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          read_strobe_n_o <= 1'b1;
          write_strobe_n_o <= 1'b1;
          byte_write_lines_o <= 2'h3;
          if (req_pend_reg) begin
            if (need_csw) begin
              chip_select_n_o <= 4'hF;
              byte_select_lines_o <= 2'h3;
              mem_data_oen_n_o <= 1'b1;
              last_valid_reg <= 1'b0;
              state_reg <= ST_WAIT;
            end else if (need_erw) begin
              // address and controls held one more cycle
              last_valid_reg <= 1'b0;
              state_reg <= ST_ERW;
            end else begin
              cur_cs_reg <= req_cs;
              cur_wr_reg <= req_wr;
              cnt_reg <= 10'h000;
              st_set_reg <= req_wr ? n_wset : n_rset;
              st_end_reg <= req_wr ? n_wset + n_wpul : n_rset + n_rpul;
              cs_set_reg <= req_wr ? n_cwset : n_crset;
              cs_end_reg <= req_wr ? n_cwset + n_cwpul : n_crset + n_crpul;
              cyc_reg <= req_wr ? n_wcyc : n_rcyc;
              mem_addr_o <= req_reg[15:0];
              mem_data_o <= req_reg[31:16] & 16'h0000 | wdata_hold(req_reg);
              byte_select_lines_o <= 2'h0;
              // Zero setup puts the lines active in the first cycle already
              read_strobe_n_o <= req_wr | (ld_st_set != 10'h000);
              write_strobe_n_o <= ~req_wr | (ld_st_set != 10'h000);
              byte_write_lines_o <= {2{~req_wr | (ld_st_set != 10'h000)}};
              chip_select_n_o <= 4'hF;
              chip_select_n_o[req_cs] <= (ld_cs_set != 10'h000);
              mem_data_oen_n_o <= ~req_wr | ~ld_ctl_set0;
              done_reg <= 1'b0;
              state_reg <= ST_RUN;
            end
          end else begin
            // Nothing pending: release every line
            chip_select_n_o <= 4'hF;
            byte_select_lines_o <= 2'h3;
            mem_data_oen_n_o <= 1'b1;
          end
        end
        ST_RUN: begin
          chip_select_n_o <= 4'hF;
          chip_select_n_o[cur_cs_reg] <= ~cs_on;
          read_strobe_n_o <= cur_wr_reg | ~st_on;
          write_strobe_n_o <= ~cur_wr_reg | ~st_on;
          byte_write_lines_o <= {2{~cur_wr_reg | ~st_on}};
          mem_data_oen_n_o <= ~cur_wr_reg | (cnt_inc < (wr_ctl_st ? st_set_reg : cs_set_reg));
          if (!cur_wr_reg && (mode_reg[cur_cs_reg][`SMT_MODE_RD] ? st_rise : cs_rise)) begin
            rd_data_reg <= mem_data_i;
          end
          cnt_reg <= cnt_inc;
          if (last_cyc) begin
            // hold is what remains of the cycle
            last_zhold_reg <= cur_wr_reg & zhold_now;
            // zero-hold write keeps address and selects one cycle past strobe rise
            if (!(cur_wr_reg && zhold_now)) begin
              byte_select_lines_o <= 2'h3;
              mem_data_oen_n_o <= 1'b1;
            end
            last_valid_reg <= 1'b1;
            last_cs_reg <= cur_cs_reg;
            last_wr_reg <= cur_wr_reg;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          state_reg <= ST_IDLE;
        end
        ST_ERW: begin
          // lines stay valid past strobe rise
          read_strobe_n_o <= 1'b1;
          write_strobe_n_o <= 1'b1;
          byte_write_lines_o <= 2'h3;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  function [15:0] wdata_hold;
    input [31:0] r;
    begin
      wdata_hold = r[31:16];
    end
  endfunction
endmodule // smt_ctrl
`default_nettype wire

// [smt_ctrl_monitor.sv]
// Port checker for the static memory timing sequencer
`timescale 1ns/1ns
`default_nettype none
module smt_mon (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_data_oen_n_o,
  input wire logic [3:0]  chip_select_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic [1:0]  byte_select_lines_o,
  input wire logic [1:0]  byte_write_lines_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence two_busy_s;
    (chip_select_n_o != 4'hF) ##1 (chip_select_n_o != 4'hF);
  endsequence
  sequence cs_swap_s;
    (chip_select_n_o != 4'hF) ##1 (chip_select_n_o == 4'hF) ##1
    (chip_select_n_o != 4'hF && chip_select_n_o != $past(chip_select_n_o, 2));
  endsequence
  cs_onehot_a: assert property ($onehot0(~chip_select_n_o))
    else $error("two selects active");
  cs_steady_a: assert property (two_busy_s |-> $stable(chip_select_n_o))
    else $error("select changed without idle cycle");
  idle_lines_a: assert property (cs_swap_s |-> $past(read_strobe_n_o) &&
    $past(byte_select_lines_o) == 2'h3 && $past(byte_write_lines_o) == 2'h3)
    else $error("line active in idle cycle");
  rd_no_drive_a: assert property (!read_strobe_n_o |-> mem_data_oen_n_o)
    else $error("data driven during read");
  wr_hold_a: assert property ($rose(write_strobe_n_o) |-> $stable(mem_addr_o) &&
    $stable(byte_select_lines_o) && $past(chip_select_n_o) != 4'hF)
    else $error("address moved at write strobe rise");
  no_overlap_a: assert property (!(!read_strobe_n_o && !write_strobe_n_o))
    else $error("read and write strobes overlap");
  strobe_in_cyc_a: assert property ((!read_strobe_n_o || !write_strobe_n_o) |->
    byte_select_lines_o != 2'h3)
    else $error("strobe outside access");
  rdata_hold_a: assert property (!$past(rd_i) |-> $stable(rdata_o))
    else $error("read data moved without read");
endmodule // smt_mon
bind smt_ctrl smt_mon i_smt_mon (.mclk_i(mclk_i), .resetn_i(resetn_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .mem_addr_o(mem_addr_o), .mem_data_oen_n_o(mem_data_oen_n_o), .chip_select_n_o(chip_select_n_o),
  .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
  .byte_select_lines_o(byte_select_lines_o), .byte_write_lines_o(byte_write_lines_o));
`default_nettype wire

// [smt_mem_model.sv]
// Memory device model: address-keyed read data, write log, phase length counts
`timescale 1ns/1ns
`default_nettype none
module smt_mem (
  input  wire logic        mclk_i,
  input  wire logic        lag_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [1:0]  bs_n_i,
  output logic      [15:0] rdata_o,
  output logic             wr_fb_o,
  output logic      [15:0] wlog_o,
  output logic      [9:0]  set_o,
  output logic      [9:0]  pul_o,
  output logic      [9:0]  cyc_o
);
  logic        fb_q = 1'b1;
  logic        bs_q = 1'b1;
  logic        stb;
  logic [15:0] pat;
  assign pat = addr_i ^ 16'hA5C3;
  assign stb = !(rd_n_i && wr_n_i);
  // data until strobe rise
  // Released bus shows the inverse, so a late sample cannot match
  assign rdata_o = (!rd_n_i && cs_n_i != 4'hF) ? pat : ~pat;
  assign wr_fb_o = lag_i ? fb_q : wr_n_i;
  always @(posedge mclk_i) begin
    fb_q <= wr_n_i;
    bs_q <= &bs_n_i;
    if (!wr_n_i && cs_n_i != 4'hF) begin
      wlog_o <= wdata_i;
    end
    if (bs_n_i != 2'h3 && bs_q) begin
      cyc_o <= 10'h001;
      pul_o <= {9'h0, stb};
      set_o <= {9'h0, !stb};
    end else if (bs_n_i != 2'h3) begin
      cyc_o <= cyc_o + 10'h001;
      if (stb) begin
        pul_o <= pul_o + 10'h001;
      end else if (pul_o == 10'h000) begin
        set_o <= set_o + 10'h001;
      end
    end
  end
endmodule // smt_mem
`default_nettype wire

// [tb_smt_ctrl.sv]
// Self-checking bench for the static memory timing sequencer
`timescale 1ns/1ns
`default_nettype none
`include "smt_defs.vh"
module tb_smt_ctrl;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        lag = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic [15:0] mem_rd, mem_addr, mem_wd, wlog;
  logic        oen_n, wr_n, rd_n, fb;
  logic [3:0]  cs_n;
  logic [1:0]  bs_n, bw_n;
  logic [9:0]  set_c, pul_c, cyc_c;
  logic [31:0] rv [0:3] = '{`SMT_RST_SETUP, `SMT_RST_PULSE, `SMT_RST_CYCLE, {30'h0, `SMT_RST_MODE}};
  int          err_count = 0;
  int          checked = 0;
  int          i, k;
  smt_ctrl i_smt_ctrl (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mem_data_i(mem_rd), .write_strobe_fb_i(fb),
    .mem_addr_o(mem_addr), .mem_data_o(mem_wd), .mem_data_oen_n_o(oen_n), .chip_select_n_o(cs_n),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .byte_select_lines_o(bs_n),
    .byte_write_lines_o(bw_n));
  smt_mem i_smt_mem (.mclk_i(mclk_i), .lag_i(lag), .addr_i(mem_addr), .wdata_i(mem_wd), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .bs_n_i(bs_n), .rdata_o(mem_rd), .wr_fb_o(fb), .wlog_o(wlog),
    .set_o(set_c), .pul_o(pul_c), .cyc_o(cyc_c));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask
  // Bounded status poll; a hang ends the run as a mismatch
  task automatic poll(input logic [2:0] m, input logic [2:0] v);
    for (k = 0; k < 2000; k++) begin
      rd(`SMT_OFF_STATUS);
      if ((d[2:0] & m) === v) return;
    end
    err_count++;
    wrap_up();
  endtask
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      rd(8'(i * 4));
      chk(d, rv[i % 4]);
    end
    rd(8'h4C);
    chk(d, 32'h00000000);
    wr(8'h10, 32'h21210000);
    wr(8'h14, 32'h41410101);
    wr(8'h18, 32'h01810003);
    wr(8'h20, 32'h00000202);
    wr(8'h24, 32'h01010303);
    wr(8'h28, 32'h00030005);
    rd(8'h18);
    chk(d, 32'h01810003);
    wr(`SMT_OFF_REQ, 32'h00010123);
    poll(3'h7, 3'h4);
    chk({22'h0, set_c}, 32'h00000081);
    chk({22'h0, pul_c}, 32'h00000101);
    chk({22'h0, cyc_c}, 32'h00000301);
    rd(`SMT_OFF_RDATA);
    chk({16'h0, d[15:0]}, 32'h0000A4E0);
    lag <= 1'b1;
    wr(`SMT_OFF_REQ, 32'h00000055);
    poll(3'h2, 3'h0);
    wr(`SMT_OFF_REQ, 32'h5A0E0200);
    poll(3'h2, 3'h0);
    wr(`SMT_OFF_REQ, 32'h00020077);
    poll(3'h7, 3'h4);
    rd(`SMT_OFF_RDATA);
    chk({16'h0, d[15:0]}, 32'h0000A5B4);
    chk({16'h0, wlog}, 32'h00005A0E);
    wrap_up();
  end
endmodule // tb_smt_ctrl
`default_nettype wire
